//--- src/emi_pkg.sv
package emi_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   // cycles a strobe stays low in one access
   localparam logic [1:0] STROBE_CYCLES = 2'h2;
   localparam logic [1:0] PORT_D_RESET  = 2'h0;
   localparam logic       DRIVE_RESET   = 1'b0;
   localparam logic       CS0_SEL_RESET = 1'b1;
   localparam logic       CS1_SEL_RESET = 1'b1;

   typedef struct packed {
      logic              write;
      logic              data_space;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic       pin_out;
      logic       pin_oe;
      logic       pullup_en;
   } pin_drive_t;
endpackage

//--- src/sel_pin.sv
`timescale 1ns/10ps
`default_nettype none
// one shared select/port pin: memory select or general-purpose port bit
module sel_pin
   import emi_pkg::*;
(
   input  wire logic  chip_sel_mode,
   input  wire logic  bus_active,
   input  wire logic  sel_active_n,
   input  wire logic  idle_drive,
   input  wire logic  gpio_dir_out,
   input  wire logic  gpio_out,
   input  wire logic  gpio_pullup,
   output var pin_drive_t drive
);
   always_comb begin
      if (chip_sel_mode) begin
         drive.pin_out   = bus_active ? sel_active_n : 1'b1;
         drive.pin_oe    = bus_active | idle_drive;
         drive.pullup_en = gpio_pullup;
      end else begin
         drive.pin_out   = gpio_out;
         drive.pin_oe    = gpio_dir_out;
         drive.pullup_en = gpio_pullup;
      end
   end
endmodule
`default_nettype wire

//--- src/ext_mem_strobe_select.sv
`timescale 1ns/10ps
`default_nettype none
module ext_mem_strobe_select
   import emi_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              req_valid,
   input  wire mem_req_t          req,
   output logic                   req_ready,
   output logic                   rdata_valid,
   output logic [DATA_W-1:0]      rdata,
   input  wire logic              idle_bus_drive_bit,
   input  wire logic              pullup_ctrl_bit,
   input  wire logic [1:0]        port_d_pullup_reg,
   input  wire logic [1:0]        port_d_dir,
   input  wire logic [1:0]        port_d_out,
   input  wire logic [1:0]        chip_sel_mode_cfg,
   input  wire logic              chip_sel_mode_load,
   output logic [1:0]             port_d_in,
   output logic [ADDR_W-1:0]      external_address_bus,
   input  wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe,
   output logic                   wr_strobe_n,
   output logic                   wr_strobe_oe,
   output logic                   wr_strobe_pullup,
   output logic                   rd_strobe_n,
   output logic                   rd_strobe_oe,
   output logic                   program_space_sel_n,
   output logic                   chip_sel_zero_oe,
   output logic                   chip_sel_zero_pullup,
   output logic                   data_space_sel_n,
   output logic                   chip_sel_one_oe,
   output logic                   chip_sel_one_pullup
);
   typedef enum {IDLE, WRITE, READ} state_t;

   state_t            state_q, state_d;
   logic [1:0]        cnt_q, cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic              rvalid_q, rvalid_d;
   logic              rd_tail_q, rd_tail_d;
   logic              dspace_q, dspace_d;
   logic [1:0]        mode_q, mode_d;
   logic [1:0]        sync1_q, sync2_q;
   logic [DATA_W-1:0] din1_q, din2_q;
   logic              active;
   pin_drive_t        cs0_drive, cs1_drive;

   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      rdata_d  = rdata_q;
      dspace_d = dspace_q;
      rvalid_d = 1'b0;
      rd_tail_d = 1'b0;
      mode_d   = chip_sel_mode_load ? chip_sel_mode_cfg : mode_q;
      // data pins lag two flops, so the word seen while the read strobe
      // was low is loaded into din2_q on the edge where the strobe rises and is taken one edge later
      if (rd_tail_q) begin
         rdata_d  = din2_q;
         rvalid_d = 1'b1;
      end
      case (state_q)
         IDLE: begin
            if (req_valid) begin
               addr_d   = req.addr;
               wdata_d  = req.wdata;
               dspace_d = req.data_space;
               cnt_d    = STROBE_CYCLES;
               state_d  = req.write ? WRITE : READ;
            end
         end
         WRITE: begin
            cnt_d = cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
               state_d = IDLE;
            end
         end
         READ: begin
            cnt_d = cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
               rd_tail_d = 1'b1;
               state_d   = IDLE;
            end
         end
         default: state_d = IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q  <= IDLE;
         cnt_q    <= 2'h0;
         addr_q   <= '0;
         wdata_q  <= '0;
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
         rd_tail_q <= 1'b0;
         dspace_q <= 1'b0;
         mode_q   <= {CS1_SEL_RESET, CS0_SEL_RESET};
         sync1_q  <= 2'h0;
         sync2_q  <= 2'h0;
         din1_q   <= '0;
         din2_q   <= '0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         rd_tail_q <= rd_tail_d;
         dspace_q <= dspace_d;
         mode_q   <= mode_d;
         sync1_q  <= {data_space_sel_n, program_space_sel_n};
         sync2_q  <= sync1_q;
         din1_q   <= data_in;
         din2_q   <= din1_q;
      end
   end

   assign active               = (state_q != IDLE);
   assign req_ready            = !active;
   assign rdata_valid          = rvalid_q;
   assign rdata                = rdata_q;
   assign external_address_bus = addr_q;
   assign wr_strobe_n          = !(state_q == WRITE);
   assign rd_strobe_n          = !(state_q == READ);
   assign wr_strobe_oe         = active | idle_bus_drive_bit;
   assign rd_strobe_oe         = active | idle_bus_drive_bit;
   assign wr_strobe_pullup     = !pullup_ctrl_bit;
   assign data_out             = wdata_q;
   assign data_oe              = (state_q == WRITE);
   // select pins readback, sampled through two flops
   assign port_d_in            = sync2_q;

   sel_pin u_cs0 (
      .chip_sel_mode (mode_q[0]),
      .bus_active    (active),
      .sel_active_n  (dspace_q),
      .idle_drive    (idle_bus_drive_bit),
      .gpio_dir_out  (port_d_dir[0]),
      .gpio_out      (port_d_out[0]),
      .gpio_pullup   (port_d_pullup_reg[0]),
      .drive         (cs0_drive)
   );

   sel_pin u_cs1 (
      .chip_sel_mode (mode_q[1]),
      .bus_active    (active),
      .sel_active_n  (!dspace_q),
      .idle_drive    (idle_bus_drive_bit),
      .gpio_dir_out  (port_d_dir[1]),
      .gpio_out      (port_d_out[1]),
      .gpio_pullup   (port_d_pullup_reg[1]),
      .drive         (cs1_drive)
   );

   assign program_space_sel_n  = cs0_drive.pin_out;
   assign chip_sel_zero_oe     = cs0_drive.pin_oe;
   assign chip_sel_zero_pullup = cs0_drive.pullup_en;
   assign data_space_sel_n     = cs1_drive.pin_out;
   assign chip_sel_one_oe      = cs1_drive.pin_oe;
   assign chip_sel_one_pullup  = cs1_drive.pullup_en;
endmodule
`default_nettype wire

//--- testbench/ext_mem_strobe_select_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ext_mem_strobe_select_monitor
   import emi_pkg::*;
(
   input wire logic              clk, rst_b, req_valid, req_ready,
   input wire mem_req_t          req,
   input wire logic              rdata_valid, data_oe, idle_bus_drive_bit,
   input wire logic              wr_strobe_n, wr_strobe_oe, rd_strobe_n,
   input wire logic              pullup_ctrl_bit, wr_strobe_pullup,
   input wire logic              program_space_sel_n, data_space_sel_n,
   input wire logic [ADDR_W-1:0] external_address_bus
);
   wire logic tk;
   assign tk = req_valid & req_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_wr;
      tk && req.write |=> !wr_strobe_n [*2] ##1 wr_strobe_n;
   endproperty
   a_wr: assert property (p_wr) else $error("write strobe width");
   property p_doe; !wr_strobe_n |-> data_oe; endproperty
   a_doe: assert property (p_doe) else $error("data not driven");
   property p_ex; wr_strobe_n || rd_strobe_n; endproperty
   a_ex: assert property (p_ex) else $error("both strobes low");
   property p_adr;
      $fell(wr_strobe_n) |=> $stable(external_address_bus);
   endproperty
   a_adr: assert property (p_adr) else $error("address moved");
   property p_idl;
      req_ready |-> wr_strobe_oe == idle_bus_drive_bit;
   endproperty
   a_idl: assert property (p_idl) else $error("idle drive");
   property p_pu; wr_strobe_pullup != pullup_ctrl_bit; endproperty
   a_pu: assert property (p_pu) else $error("strobe pullup");
   property p_cs0;
      tk && !req.data_space |=> !program_space_sel_n [*2];
   endproperty
   a_cs0: assert property (p_cs0) else $error("program select");
   property p_cs1;
      tk && req.data_space |=> !data_space_sel_n [*2];
   endproperty
   a_cs1: assert property (p_cs1) else $error("data select");
   property p_rd;
      tk && !req.write |=> !rd_strobe_n && !data_oe ##3 rdata_valid;
   endproperty
   a_rd: assert property (p_rd) else $error("read cycle");
endmodule
bind ext_mem_strobe_select ext_mem_strobe_select_monitor i_mon (.*);
`default_nettype wire

//--- testbench/sram_model.sv
`timescale 1ns/10ps
`default_nettype none
module sram_model (
   input wire logic        clk, wr_strobe_n, rd_strobe_n,
   input wire logic [23:0] external_address_bus,
   input wire logic [15:0] data_out,
   output logic [15:0]     data_in
);
   logic [15:0] mem [16];
   logic [15:0] last = 16'h0;
   always @(posedge wr_strobe_n)
      mem[external_address_bus[3:0]] <= data_out;
   always @(posedge clk) last <= data_in;
   // released bus keeps toggling so a stale value never looks valid
   assign data_in = rd_strobe_n ? ~last
                                : mem[external_address_bus[3:0]];
endmodule
`default_nettype wire

//--- testbench/ext_mem_strobe_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ext_mem_strobe_select_tb;
   import emi_pkg::*;
   typedef struct packed { mem_req_t r; logic [15:0] e; } row_t;
   logic clk = 0, rst_b = 0, req_valid = 0, idle_bus_drive_bit = 0;
   logic pullup_ctrl_bit = 0, chip_sel_mode_load = 0;
   logic [1:0] port_d_pullup_reg = 2'h3, port_d_dir = 2'h0, port_d_out = 2'h0;
   logic [1:0] chip_sel_mode_cfg = 2'h3, port_d_in;
   mem_req_t req = '0;
   logic [15:0] data_in, data_out, rdata;
   logic [23:0] external_address_bus;
   logic req_ready, rdata_valid, data_oe, wr_strobe_n, wr_strobe_oe;
   logic wr_strobe_pullup, rd_strobe_n, rd_strobe_oe, program_space_sel_n;
   logic chip_sel_zero_oe, chip_sel_zero_pullup, data_space_sel_n;
   logic chip_sel_one_oe, chip_sel_one_pullup;
   int error_cnt = 0, total_checks = 0;
   row_t rows [4] = '{{1'b1, 1'b0, 24'hFFFFF1, 16'hA5C3, 16'h0},
      {1'b1, 1'b1, 24'h000002, 16'h5A3C, 16'h0},
      {1'b0, 1'b0, 24'hFFFFF1, 16'h0, 16'hA5C3},
      {1'b0, 1'b1, 24'h000002, 16'h0, 16'h5A3C}};
   ext_mem_strobe_select i_dut (.*);
   sram_model i_mem (.*);
   initial forever #25 clk = ~clk;
   task chk(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task acc(input row_t w);
      int k;
      k = 0;
      req = w.r;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && k < 9) begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      chk(program_space_sel_n, w.r.data_space);
      chk(data_space_sel_n, !w.r.data_space);
      chk({wr_strobe_n, rd_strobe_n}, {!w.r.write, w.r.write});
      chk(external_address_bus, w.r.addr);
      chk({data_oe, data_out}, {w.r.write, w.r.wdata});
      repeat (2) @(negedge clk);
      chk({wr_strobe_n, rd_strobe_n}, 2'h3);
      if (!w.r.write) begin
         @(negedge clk);
         chk({rdata_valid, rdata}, {1'b1, w.e});
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200us;
      error_cnt++;
      final_report;
   end
   initial begin
      repeat (4) @(negedge clk);
      chk({wr_strobe_oe, wr_strobe_n}, 2'h1);
      rst_b = 1'b1;
      foreach (rows[i]) acc(rows[i]);
      idle_bus_drive_bit = 1'b1;
      pullup_ctrl_bit = 1'b1;
      port_d_pullup_reg = 2'h1;
      @(negedge clk);
      chk({wr_strobe_oe, rd_strobe_oe, chip_sel_zero_oe, chip_sel_one_oe},
          4'hF);
      chk({program_space_sel_n, data_space_sel_n}, 2'h3);
      chk({wr_strobe_pullup, chip_sel_one_pullup, chip_sel_zero_pullup},
          3'h1);
      {idle_bus_drive_bit, chip_sel_mode_cfg, chip_sel_mode_load} = 4'h5;
      port_d_dir = 2'h1;
      @(negedge clk);
      chip_sel_mode_load = 1'b0;
      repeat (3) @(negedge clk);
      chk({chip_sel_zero_oe, program_space_sel_n, chip_sel_one_oe}, 3'h4);
      chk(port_d_in[0], 1'b0);
      rst_b = 1'b0;
      @(negedge clk);
      rst_b = 1'b1;
      acc(rows[2]);
      final_report;
   end
endmodule
`default_nettype wire
